//--- bench/sicp_core_assertions.sv
// concurrent checks on the input control and priority block ports
`timescale 1ns/10ps
`default_nettype none
module sicp_core_assertions (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       trip_reset,
	input wire logic       cooling_busy,
	input wire logic       start_rev,
	input wire logic       use_slow,
	input wire logic       save_pulse,
	input wire logic       motor_off,
	input wire logic       gf_enable,
	input wire logic       runup_done,
	input wire logic       bus_ctrl_en,
	input wire logic [2:0] prio_holder,
	input wire logic [5:0] out_pins,
	input wire logic       fan_on,
	input wire logic       bypass_closed,
	input wire logic       fault_group
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----
	// sequences
	// ----
	// an acknowledge is one cycle long and never launched in cooling time
	sequence s_trip_ok;
		!$past(cooling_busy) ##1 !trip_reset;
	endsequence
	sequence s_after_reset;
		$past(rst_n);
	endsequence
	AST_TRIP: assert property (trip_reset |-> s_trip_ok)
		else $error("trip reset pulse wrong");
	AST_REV_SLOW: assert property (start_rev |-> use_slow)
		else $error("reverse start without slow speed");
	AST_SAVE_OFF: assert property (save_pulse |-> $past(motor_off))
		else $error("save while motor driven");
	AST_GF_RUNUP: assert property (gf_enable |-> $past(runup_done))
		else $error("ground fault enabled before run-up");
	AST_PRIO_UP: assert property (s_after_reset |-> prio_holder >= $past(prio_holder))
		else $error("priority fell");
	AST_OUT_FAULT: assert property (s_after_reset |-> out_pins[3] == $past(fault_group))
		else $error("group fault output wrong");
	AST_OUT_BYP_FAN: assert property (s_after_reset |->
		out_pins[5] == $past(fan_on) && out_pins[4] == $past(bypass_closed))
		else $error("bypass or fan output wrong");
	AST_BUS_CTRL: assert property (bus_ctrl_en |-> prio_holder <= 3'h1)
		else $error("bus control while inputs hold priority");
endmodule // sicp_core_assertions
bind sicp_core sicp_core_assertions i_sicp_core_assertions (.clk, .rst_n, .trip_reset,
	.cooling_busy, .start_rev, .use_slow, .save_pulse, .motor_off, .gf_enable, .runup_done,
	.bus_ctrl_en, .prio_holder, .out_pins, .fan_on, .bypass_closed, .fault_group);
`default_nettype wire

//--- bench/sicp_core_test.sv
// self-checking bench for the input control and priority block
`timescale 1ns/10ps
`default_nettype none
`include "sicp_defs.vh"
module sicp_core_test;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0;
	logic [7:0]  addr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic [3:0]  ctl_in = 0;
	logic [4:0]  prio_req = 0;
	logic        fault_group = 0, fault_bypassable = 0, cooling_busy = 0;
	logic [1:0]  phase_dir = 0, conn_type = 0, param_sel;
	logic [11:0] meas_current = 0, phase_current;
	logic        runup_done, bypass_closed, fan_on, motor_off, start_fwd, start_rev;
	logic        use_slow, stop_req, trip_reset, bus_ctrl_en, gf_enable, save_pulse;
	logic        restore_pulse, factory_pulse, bus_load_pulse;
	logic [5:0]  out_pins;
	logic [2:0]  prio_holder;
	int          miscompares = 0, checks = 0, prio = 0, dl = 0;
	logic [4:0]  rq [4] = '{5'h02, 5'h0A, 5'h11, 5'h01};
	always #10 clk = ~clk;
	sicp_core i_sicp_core (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .ctl_in, .prio_req,
		.fault_group, .fault_bypassable, .cooling_busy, .runup_done, .bypass_closed, .fan_on,
		.motor_off, .phase_dir, .conn_type, .meas_current, .start_fwd, .start_rev, .use_slow,
		.param_sel, .stop_req, .trip_reset, .bus_ctrl_en, .gf_enable, .save_pulse,
		.restore_pulse, .factory_pulse, .bus_load_pulse, .out_pins, .prio_holder,
		.phase_current);
	sicp_motor_sim i_sicp_motor_sim (.clk, .rst_n, .start_fwd, .start_rev, .runup_done,
		.bypass_closed, .fan_on, .motor_off);
	// ----
	// bus cycles, compare and model
	// ----
	task automatic summarize;
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic set_in(input logic [3:0] c);
		@(posedge clk);
		ctl_in <= c;
		repeat (4) @(posedge clk);
	endtask
	// an action with no carrier is off; with several it needs them all
	function automatic bit on(input logic [15:0] t, input logic [3:0] c, input logic [3:0] a);
		int n, k;
		n = 0;
		k = 0;
		for (int i = 0; i < 4; i++)
			if (t[4*i+:4] == a) begin
				n++;
				k += c[i];
			end
		return n > 0 && n == k;
	endfunction
	task automatic run_tbl(input logic [15:0] t);
		logic [31:0] v;
		bit f1, f2, f3, man, qs, ok, sf, sr, tp, rv;
		int m;
		set_in(4'h0);
		wr_reg(`SICP_ADDR_ACT0, {16'h0, t});
		tp = 0;
		repeat (40) begin
			v = $urandom;
			@(posedge clk);
			ctl_in <= v[3:0];
			fault_group <= v[4];
			fault_bypassable <= v[5];
			cooling_busy <= v[6];
			meas_current <= {1'b0, v[18:8]};
			m = v[18:8];
			f1 = on(t, v[3:0], `SICP_ACT_FWD1);
			f2 = on(t, v[3:0], `SICP_ACT_FWD2);
			f3 = on(t, v[3:0], `SICP_ACT_FWD3);
			man = on(t, v[3:0], `SICP_ACT_MANUAL);
			qs = on(t, v[3:0], `SICP_ACT_QSTOP);
			ok = (prio == 2 || man) && !qs &&
				(!v[4] || (on(t, v[3:0], `SICP_ACT_EMERG) && v[5]));
			sf = (f1 | f2 | f3) && ok;
			rv = on(t, v[3:0], `SICP_ACT_REV1) | on(t, v[3:0], `SICP_ACT_REV2) |
				on(t, v[3:0], `SICP_ACT_REV3);
			sr = ok && on(t, v[3:0], `SICP_ACT_SLOW) && rv;
			@(posedge clk);
			#1;
			cmp("start_fwd", sf, start_fwd);
			cmp("start_rev", sr, start_rev);
			cmp("use_slow", on(t, v[3:0], `SICP_ACT_SLOW) && (prio == 2 || man) &&
				(f1 | f2 | f3 | rv), use_slow);
			if (sf && f1 + f2 + f3 == 1)
				cmp("param_sel", f1 ? 0 : (f2 ? 1 : 2), param_sel);
			cmp("trip_reset", on(t, v[3:0], `SICP_ACT_TRIPRST) && !tp && !v[6], trip_reset);
			tp = on(t, v[3:0], `SICP_ACT_TRIPRST);
			cmp("bus_ctrl_en", !man && prio <= 1, bus_ctrl_en);
			if (qs)
				cmp("stop_req", 1, stop_req);
			cmp("phase_current", dl ? (m * `SICP_DELTA_MUL) >> 8 : m, phase_current);
		end
	endtask
	task automatic cmd(input logic [31:0] c, input int b, input logic [3:0] e);
		wr_reg(`SICP_ADDR_CTRL, c);
		wr_reg(`SICP_ADDR_CMD, 32'h1 << b);
		cmp("pulses", e, {save_pulse, restore_pulse, factory_pulse, bus_load_pulse});
	endtask
	task automatic wait_off;
		int n;
		n = 0;
		while (motor_off !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 50) begin
			miscompares++;
			summarize();
		end
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(32'h2CF60635));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(`SICP_ADDR_PRIO);
		cmp("prio reset", 0, d);
		rd_reg(8'h20);
		cmp("unmapped", 0, d);
		run_tbl(16'h1879);
		run_tbl(16'h0B08);
		prio_req <= 5'h04;
		prio = 2;
		wr_reg(`SICP_ADDR_CTRL, 32'h2);
		dl = 1;
		run_tbl(16'h243A);
		wr_reg(`SICP_ADDR_CTRL, 32'h0);
		dl = 0;
		run_tbl(16'h5366);
		fault_group <= 1'b0;
		set_in(4'h3);
		cmd(32'h0, `SICP_CMD_SAVE, 4'h0);
		rd_reg(`SICP_ADDR_STATUS);
		cmp("save refused", 1, d[2]);
		set_in(4'h0);
		wait_off();
		cmd(32'h0, `SICP_CMD_SAVE, 4'h8);
		phase_dir <= 2'h2;
		conn_type <= 2'h1;
		set_in(4'h1);
		wr_reg(`SICP_ADDR_ACT0, 32'h0);
		rd_reg(`SICP_ADDR_ACT0);
		cmp("act kept", 32'h5366, d);
		rd_reg(`SICP_ADDR_STATUS);
		cmp("status", 5'h0D, {d[11:8], d[3]});
		rd_reg(`SICP_ADDR_STATUS);
		cmp("reject cleared", 0, d[3]);
		set_in(4'h0);
		wr_reg(`SICP_ADDR_ACT0, 32'h243A);
		cmd(32'h0, `SICP_CMD_RESTORE, 4'h4);
		rd_reg(`SICP_ADDR_ACT0);
		cmp("restored", 32'h5366, d);
		cmd(32'h0, `SICP_CMD_BUSSTART, 4'h1);
		cmd(32'h1, `SICP_CMD_BUSSTART, 4'h0);
		cmd(32'h0, `SICP_CMD_FACTORY, 4'h2);
		rd_reg(`SICP_ADDR_ACT0);
		cmp("factory act", 0, d);
		rd_reg(`SICP_ADDR_STATUS);
		cmp("quick start needed", 1, d[4]);
		wr_reg(`SICP_ADDR_CTRL, 32'h34);
		rd_reg(`SICP_ADDR_CTRL);
		cmp("default forced", 0, d[6:4]);
		foreach (rq[i]) begin
			@(posedge clk);
			prio_req <= rq[i];
			for (int r = 0; r < 5; r++)
				if (rq[i][r] && r > prio)
					prio = r;
			repeat (3) @(posedge clk);
			#1;
			cmp("prio_holder", prio, prio_holder);
			rd_reg(`SICP_ADDR_PRIO);
			cmp("prio", prio, d);
		end
		summarize();
	end
endmodule // sicp_core_test
`default_nettype wire

//--- bench/sicp_motor_sim.sv
// behavioural motor and power section seen at the block's far side
`timescale 1ns/10ps
`default_nettype none
module sicp_motor_sim #(
	parameter int RAMP = 3
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start_fwd,
	input  wire logic start_rev,
	output var  logic runup_done,
	output var  logic bypass_closed,
	output var  logic fan_on,
	output var  logic motor_off
);
	int speed;
	// coasting down takes as long as run-up, so the motor stays driven a while after stop
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			speed <= 0;
		else if (start_fwd || start_rev)
			speed <= (speed < RAMP) ? speed + 1 : RAMP;
		else
			speed <= (speed > 0) ? speed - 1 : 0;
	end
	assign runup_done = (speed == RAMP);
	assign bypass_closed = runup_done;
	assign fan_on = (speed > 0);
	assign motor_off = (speed == 0);
endmodule // sicp_motor_sim
`default_nettype wire

//--- rtl/sicp_core.v
// soft starter control input mapping and control priority arbiter
`timescale 1ns/10ps
`default_nettype none
`include "sicp_defs.vh"
// Notes on behaviour
// - action change only while input inactive
// - shared action needs all its inputs
// - trip reset ignored during cooling time
// - manual mode hands control to inputs
// - emergency start overrides bypassable group fault
// - slow speed needs slow plus start
// - quick stop always, no group fault
// - forward start uses chosen parameter set
// - reverse only with slow speed
// - trip reset on rising edge only
// - ground fault masked until run-up done
// - saving refused while motor driven
// - restore reloads last saved settings
// - factory reset reloads defaults, redo quick start
// - bus startup overwrites unless locked
// - inside-delta currents scaled by 1.73
// - outputs 4,5,6 fault, bypass, fan
// - only higher rank takes or releases; the code has no release, the rank only rises until reset
// - ranks auto0 pcbus1 inputs2 keys3 pcser4
// - default control chosen at power up
// - bus module forces default to automatic
// - report phase direction and connection type

module sicp_core #(
	parameter N_IN = 4,
	parameter CUR_W = 12
) (
	input  wire              clk,
	input  wire              rst_n,
	input  wire [7:0]        addr,
	input  wire [31:0]       wdata,
	input  wire              wr,
	input  wire              rd,
	output reg  [31:0]       rdata,
	input  wire [N_IN-1:0]   ctl_in,
	input  wire [4:0]        prio_req,
	input  wire              fault_group,
	input  wire              fault_bypassable,
	input  wire              cooling_busy,
	input  wire              runup_done,
	input  wire              bypass_closed,
	input  wire              fan_on,
	input  wire              motor_off,
	input  wire [1:0]        phase_dir,
	input  wire [1:0]        conn_type,
	input  wire [CUR_W-1:0]  meas_current,
	output reg               start_fwd,
	output reg               start_rev,
	output reg               use_slow,
	output reg  [1:0]        param_sel,
	output reg               stop_req,
	output reg               trip_reset,
	output reg               bus_ctrl_en,
	output reg               gf_enable,
	output reg               save_pulse,
	output reg               restore_pulse,
	output reg               factory_pulse,
	output reg               bus_load_pulse,
	output reg  [5:0]        out_pins,
	output reg  [2:0]        prio_holder,
	output reg  [CUR_W-1:0]  phase_current
);

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	reg [4*N_IN-1:0] act_reg;
	reg [7:0]        ctrl_reg;
	reg [2:0]        outfn_reg;
	reg              qs_needed_reg;
	reg [N_IN-1:0]   in_d_reg;
	reg              save_rej_reg;
	reg              act_rej_reg;
	reg [2:0]        prio_reg;

	wire wr_act  = wr && (addr == `SICP_ADDR_ACT0);
	wire wr_ctrl = wr && (addr == `SICP_ADDR_CTRL);
	wire wr_cmd  = wr && (addr == `SICP_ADDR_CMD);
	wire wr_outf = wr && (addr == `SICP_ADDR_OUTFN);
	wire wr_prio = wr_cmd && wdata[`SICP_CMD_PRIO_REQ];

	// ----------------------------------------
	// per input action decode
	// ----------------------------------------
	wire [N_IN-1:0] act_block;
	wire [N_IN-1:0] hit_man;
	wire [N_IN-1:0] hit_em;
	wire [N_IN-1:0] hit_slow;
	wire [N_IN-1:0] hit_qs;
	wire [N_IN-1:0] hit_tr;
	wire [N_IN-1:0] hit_f1;
	wire [N_IN-1:0] hit_f2;
	wire [N_IN-1:0] hit_f3;
	wire [N_IN-1:0] hit_r1;
	wire [N_IN-1:0] hit_r2;
	wire [N_IN-1:0] hit_r3;
	wire [N_IN-1:0] asg_tr;
	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_in
			wire [3:0] a = act_reg[4*gi+3:4*gi];
			// unassigned inputs count as satisfied so the and covers only carriers
			assign hit_man[gi]  = (a != `SICP_ACT_MANUAL)  || ctl_in[gi];
			assign hit_em[gi]   = (a != `SICP_ACT_EMERG)   || ctl_in[gi];
			assign hit_slow[gi] = (a != `SICP_ACT_SLOW)    || ctl_in[gi];
			assign hit_qs[gi]   = (a != `SICP_ACT_QSTOP)   || ctl_in[gi];
			assign hit_tr[gi]   = (a != `SICP_ACT_TRIPRST) || ctl_in[gi];
			assign hit_f1[gi]   = (a != `SICP_ACT_FWD1)    || ctl_in[gi];
			assign hit_f2[gi]   = (a != `SICP_ACT_FWD2)    || ctl_in[gi];
			assign hit_f3[gi]   = (a != `SICP_ACT_FWD3)    || ctl_in[gi];
			assign hit_r1[gi]   = (a != `SICP_ACT_REV1)    || ctl_in[gi];
			assign hit_r2[gi]   = (a != `SICP_ACT_REV2)    || ctl_in[gi];
			assign hit_r3[gi]   = (a != `SICP_ACT_REV3)    || ctl_in[gi];
			assign asg_tr[gi]   = (a == `SICP_ACT_TRIPRST);
			// a write may not change the action of an asserted input
			assign act_block[gi] = ctl_in[gi] &&
				(wdata[4*gi+3:4*gi] != a);
		end
	endgenerate

	// an action with no carrier is off, hence the any-assigned terms
	function has;
		input [4*N_IN-1:0] acts;
		input [3:0]        code;
		integer            k;
		begin
			has = 1'b0;
			for (k = 0; k < N_IN; k = k + 1)
				if (acts[4*k+3 -: 4] == code)
					has = 1'b1;
		end
	endfunction

	wire f_man  = has(act_reg, `SICP_ACT_MANUAL) && (&hit_man);
	wire f_em   = has(act_reg, `SICP_ACT_EMERG)  && (&hit_em);
	wire f_slow = has(act_reg, `SICP_ACT_SLOW)   && (&hit_slow);
	wire f_qs   = has(act_reg, `SICP_ACT_QSTOP)  && (&hit_qs);
	wire f_tr   = (|asg_tr) && (&hit_tr);
	wire f_f1   = has(act_reg, `SICP_ACT_FWD1)   && (&hit_f1);
	wire f_f2   = has(act_reg, `SICP_ACT_FWD2)   && (&hit_f2);
	wire f_f3   = has(act_reg, `SICP_ACT_FWD3)   && (&hit_f3);
	wire f_r1   = has(act_reg, `SICP_ACT_REV1)   && (&hit_r1);
	wire f_r2   = has(act_reg, `SICP_ACT_REV2)   && (&hit_r2);
	wire f_r3   = has(act_reg, `SICP_ACT_REV3)   && (&hit_r3);

	// trip reset level of the previous cycle, for edge detection
	reg  f_tr_d_reg;
	wire tr_edge = f_tr && !f_tr_d_reg;

	wire any_fwd = f_f1 || f_f2 || f_f3;
	wire any_rev = (f_r1 || f_r2 || f_r3) && f_slow;
	wire inputs_rule = (prio_reg == `SICP_RANK_INPUTS) || f_man;
	wire start_ok = !fault_group || (f_em && fault_bypassable);
	wire [1:0] sel_nx = f_f1 ? 2'h0 : f_f2 ? 2'h1 : f_f3 ? 2'h2 :
		f_r1 ? 2'h0 : f_r2 ? 2'h1 : 2'h2;

	// ----------------------------------------
	// priority arbitration
	// ----------------------------------------
	reg  [2:0] req_top;
	reg        req_any;
	integer    ri;
	always @* begin
		req_top = 3'h0;
		req_any = 1'b0;
		// later index wins, so the highest rank is kept
		for (ri = 0; ri < 5; ri = ri + 1)
			if (prio_req[ri]) begin
				req_top = ri[2:0];
				req_any = 1'b1;
			end
	end

	wire [2:0] def_rank = ctrl_reg[`SICP_CTRL_DEF_LSB+2:`SICP_CTRL_DEF_LSB];
	wire [2:0] sw_rank  = wdata[10:8];

	// ----------------------------------------
	// main sequential logic
	// ----------------------------------------
	reg                boot_reg;
	reg [4*N_IN-1:0]   saved_act_reg;
	reg [CUR_W+8:0]    scaled;
	always @* begin
		scaled = meas_current * `SICP_DELTA_MUL;
	end

	wire save_cmd = wr_cmd && wdata[`SICP_CMD_SAVE];
	wire save_ok  = save_cmd && motor_off;
	wire save_bad = save_cmd && !motor_off;
	wire rest_cmd = wr_cmd && wdata[`SICP_CMD_RESTORE];
	wire fact_cmd = wr_cmd && wdata[`SICP_CMD_FACTORY];
	wire act_bad  = wr_act && (|act_block);
	wire stat_rd  = rd && (addr == `SICP_ADDR_STATUS);

	// ----------------------------------------
	// configuration and saved copy
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_reg       <= {4*N_IN{1'b0}};
			saved_act_reg <= {4*N_IN{1'b0}};
			ctrl_reg      <= 8'h00;
			outfn_reg     <= 3'h0;
			qs_needed_reg <= 1'b1;
		end else begin
			// factory reset beats restore, restore beats a plain write
			if (fact_cmd) begin
				act_reg       <= {4*N_IN{1'b0}};
				saved_act_reg <= {4*N_IN{1'b0}};
			end else begin
				if (rest_cmd)
					act_reg <= saved_act_reg;
				else if (wr_act && !act_bad)
					act_reg <= wdata[4*N_IN-1:0];
				if (save_ok)
					saved_act_reg <= act_reg;
			end
			if (wr_ctrl) begin
				ctrl_reg <= wdata[7:0];
				if (wdata[`SICP_CTRL_BUSMOD])
					ctrl_reg[`SICP_CTRL_DEF_LSB+2:`SICP_CTRL_DEF_LSB] <=
						`SICP_RANK_AUTO;
			end
			if (wr_outf)
				outfn_reg <= wdata[2:0];
			if (fact_cmd)
				qs_needed_reg <= 1'b1;
			else if (wr_cmd && wdata[`SICP_CMD_QS_DONE])
				qs_needed_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// priority holder
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prio_reg    <= 3'h0;
			boot_reg    <= 1'b1;
			prio_holder <= 3'h0;
		end else begin
			boot_reg <= 1'b0;
			// power up default first, then strictly higher takers
			if (boot_reg)
				prio_reg <= def_rank;
			else if (req_any && req_top > prio_reg)
				prio_reg <= req_top;
			else if (wr_prio && sw_rank > prio_reg)
				prio_reg <= sw_rank;
			prio_holder <= prio_reg;
		end
	end

	// ----------------------------------------
	// motor commands from the inputs
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_d_reg    <= {N_IN{1'b0}};
			f_tr_d_reg  <= 1'b0;
			start_fwd   <= 1'b0;
			start_rev   <= 1'b0;
			use_slow    <= 1'b0;
			param_sel   <= 2'h0;
			stop_req    <= 1'b0;
			trip_reset  <= 1'b0;
			bus_ctrl_en <= 1'b0;
			gf_enable   <= 1'b0;
		end else begin
			in_d_reg    <= ctl_in;
			f_tr_d_reg  <= f_tr;
			// starts follow the inputs only while inputs rule
			start_fwd   <= inputs_rule && any_fwd && start_ok && !f_qs;
			start_rev   <= inputs_rule && any_rev && start_ok && !f_qs;
			use_slow    <= inputs_rule && f_slow && (any_fwd || any_rev);
			param_sel   <= sel_nx;
			stop_req    <= f_qs;
			trip_reset  <= tr_edge && !cooling_busy;
			bus_ctrl_en <= !f_man && (prio_reg <= `SICP_RANK_PC_BUS);
			gf_enable   <= runup_done;
		end
	end

	// ----------------------------------------
	// command pulses and status flags
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			save_pulse     <= 1'b0;
			restore_pulse  <= 1'b0;
			factory_pulse  <= 1'b0;
			bus_load_pulse <= 1'b0;
			save_rej_reg   <= 1'b0;
			act_rej_reg    <= 1'b0;
		end else begin
			save_pulse     <= save_ok;
			restore_pulse  <= rest_cmd;
			factory_pulse  <= fact_cmd;
			bus_load_pulse <= wr_cmd && wdata[`SICP_CMD_BUSSTART] &&
				!ctrl_reg[`SICP_CTRL_LOCK];
			// a new refusal wins over the clearing read in the same cycle
			if (save_bad)
				save_rej_reg <= 1'b1;
			else if (stat_rd)
				save_rej_reg <= 1'b0;
			if (act_bad)
				act_rej_reg <= 1'b1;
			else if (stat_rd)
				act_rej_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// status outputs and currents
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_pins      <= 6'h00;
			phase_current <= {CUR_W{1'b0}};
		end else begin
			out_pins      <= {fan_on, bypass_closed, fault_group, outfn_reg};
			phase_current <= ctrl_reg[`SICP_CTRL_DELTA] ?
				scaled[CUR_W+7:8] : meas_current;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			case (addr)
			`SICP_ADDR_ACT0:    rdata <= {{(32-4*N_IN){1'b0}}, act_reg};
			`SICP_ADDR_CTRL:    rdata <= {24'h000000, ctrl_reg};
			`SICP_ADDR_STATUS:  rdata <= {20'h00000, conn_type, phase_dir,
				3'h0, qs_needed_reg, act_rej_reg, save_rej_reg,
				gf_enable, bus_ctrl_en};
			`SICP_ADDR_PRIO:    rdata <= {29'h00000000, prio_reg};
			`SICP_ADDR_CUR_IN:  rdata <= {{(32-N_IN){1'b0}}, in_d_reg};
			`SICP_ADDR_CUR_OUT: rdata <= {26'h0000000, out_pins};
			`SICP_ADDR_OUTFN:   rdata <= {29'h00000000, outfn_reg};
			default:            rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end

endmodule // sicp_core
`default_nettype wire

//--- shared/sicp_defs.vh
// constants for the soft starter input control and priority block
`ifndef SICP_DEFS_VH
`define SICP_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SICP_ADDR_ACT0     8'h00
`define SICP_ADDR_CTRL     8'h04
`define SICP_ADDR_STATUS   8'h08
`define SICP_ADDR_PRIO     8'h0C
`define SICP_ADDR_CMD      8'h10
`define SICP_ADDR_CUR_IN   8'h14
`define SICP_ADDR_CUR_OUT  8'h18
`define SICP_ADDR_OUTFN    8'h1C

// ----------------------------------------
// input action codes, 4 bits each
// ----------------------------------------
`define SICP_ACT_NONE      4'h0
`define SICP_ACT_MANUAL    4'h1
`define SICP_ACT_EMERG     4'h2
`define SICP_ACT_SLOW      4'h3
`define SICP_ACT_QSTOP     4'h4
`define SICP_ACT_TRIPRST   4'h5
`define SICP_ACT_FWD1      4'h6
`define SICP_ACT_FWD2      4'h7
`define SICP_ACT_FWD3      4'h8
`define SICP_ACT_REV1      4'h9
`define SICP_ACT_REV2      4'hA
`define SICP_ACT_REV3      4'hB

// ----------------------------------------
// control priority ranks
// ----------------------------------------
`define SICP_RANK_AUTO     3'h0
`define SICP_RANK_PC_BUS   3'h1
`define SICP_RANK_INPUTS   3'h2
`define SICP_RANK_KEYS     3'h3
`define SICP_RANK_PC_SER   3'h4

// ----------------------------------------
// control bits, command bits, run states
// ----------------------------------------
`define SICP_CTRL_LOCK     0
`define SICP_CTRL_DELTA    1
`define SICP_CTRL_BUSMOD   2
`define SICP_CTRL_DEF_LSB  4
`define SICP_CMD_SAVE      0
`define SICP_CMD_RESTORE   1
`define SICP_CMD_FACTORY   2
`define SICP_CMD_QS_DONE   3
`define SICP_CMD_BUSSTART  4
`define SICP_CMD_PRIO_REQ  5

`define SICP_ST_IDLE       2'h0
`define SICP_ST_RAMP       2'h1
`define SICP_ST_RUN        2'h2
`define SICP_ST_STOP       2'h3

// delta scaling 1.73 as 443/256
`define SICP_DELTA_MUL     9'h1BB

`endif
